// ---- sfrl_pkg.sv ----
/*
  Constants for the synthesizer ratio, output enable and lock criterion register bank.
  Assumes a byte-wide configuration port that addresses registers by byte offset.
*/
// Overview of operation
// - ratio register: bits 31:16 unsigned numerator, bits 15:0 unsigned denominator.
// - synth frequency equals base times multiplier times sixteen times numerator over denominator.
// - synth 0 output driven only while enable bit 0 set; synth 1 by bit 1.
// - lock status follows the criterion chosen by the two-bit field.
// - criterion 00: phase error below 36 us throughout 10 s.
// - criterion 01: phase error below 1 us throughout 1 s.
// - criterion 10: phase error below 10 us throughout 1 s.
// - criterion 11: phase error below 10 us throughout 10 s.
// - base frequency is an unsigned 16-bit hertz value from its own input port.
package sfrl_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [6:0] SFRL_RATIO_OFS = 7'h5C; // occupies 0x5C..0x5F, msb first
  localparam logic [6:0] SFRL_OUT_EN_OFS = 7'h71;
  localparam logic [6:0] SFRL_LOCK_SEL_OFS = 7'h72;
  // ----------------------------------------
  // reset values and fields
  // ----------------------------------------
  localparam logic [31:0] SFRL_RATIO_RST = 32'h00010001;
  localparam logic [7:0] SFRL_OUT_EN_RST = 8'h03;
  localparam logic [7:0] SFRL_LOCK_SEL_RST = 8'hAA;
  localparam int SFRL_NUM_LSB = 16;
  localparam int SFRL_SYNTH0_BIT = 0;
  localparam int SFRL_SYNTH1_BIT = 1;
  localparam int SFRL_FREQ_SCALE = 16;
  // ----------------------------------------
  // lock criteria: thresholds in ns, windows in ms
  // ----------------------------------------
  localparam int SFRL_CLK_MHZ = 125;
  localparam int SFRL_TICK_NS = 1000; // one qualification tick per microsecond
  localparam int SFRL_TICK_CYC = SFRL_TICK_NS * SFRL_CLK_MHZ / 1000;
  localparam int SFRL_THR36_NS = 36000;
  localparam int SFRL_THR1_NS = 1000;
  localparam int SFRL_THR10_NS = 10000;
  localparam int SFRL_WIN10_MS = 10000;
  localparam int SFRL_WIN1_MS = 1000;
  typedef enum logic [1:0] {
    SFRL_CRIT_36US_10S = 2'b00,
    SFRL_CRIT_1US_1S = 2'b01,
    SFRL_CRIT_10US_1S = 2'b10,
    SFRL_CRIT_10US_10S = 2'b11
  } sfrl_crit_t;
endpackage

// ---- sfrl_lock_qual.sv ----
/*
  Lock qualifier: declares lock once phase error stayed under a threshold for a window.
  Assumes phase error magnitude in ns from the DPLL on the same clock.
*/
`timescale 1ns/100ps
module sfrl_lock_qual
  import sfrl_pkg::*;
#(
  parameter int TICK_CYC = SFRL_TICK_CYC,
  parameter int WIN10_TICKS = SFRL_WIN10_MS * 1000,
  parameter int WIN1_TICKS = SFRL_WIN1_MS * 1000
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [1:0] crit_i,
  input wire logic [31:0] phase_err_ns_i,
  output logic locked_o
);
  typedef struct packed {
    logic [15:0] tick;
    logic [31:0] run;
    logic [1:0] crit;
    logic locked;
  } sfrl_lq_t;
  sfrl_lq_t st_reg, st_next;
  logic [31:0] thr;
  logic [31:0] win;

  // threshold and window from the criterion field
  always_comb begin
    case (crit_i)
      SFRL_CRIT_36US_10S: begin thr = 32'(SFRL_THR36_NS); win = 32'(WIN10_TICKS); end
      SFRL_CRIT_1US_1S: begin thr = 32'(SFRL_THR1_NS); win = 32'(WIN1_TICKS); end
      SFRL_CRIT_10US_1S: begin thr = 32'(SFRL_THR10_NS); win = 32'(WIN1_TICKS); end
      default: begin thr = 32'(SFRL_THR10_NS); win = 32'(WIN10_TICKS); end
    endcase
  end

  // any excursion or criterion change restarts the window, so lock is never granted early
  always_comb begin
    st_next = st_reg;
    st_next.crit = crit_i;
    st_next.tick = (st_reg.tick >= 16'(TICK_CYC - 1)) ? 16'h0000 : st_reg.tick + 16'h0001;
    if (phase_err_ns_i >= thr || st_reg.crit != crit_i) begin
      st_next.run = 32'h00000000;
      st_next.tick = 16'h0000;
      st_next.locked = 1'b0;
    end else if (st_reg.tick >= 16'(TICK_CYC - 1)) begin
      if (st_reg.run + 32'h00000001 >= win) begin
        st_next.locked = 1'b1;
      end else begin
        st_next.run = st_reg.run + 32'h00000001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg <= '{tick: 16'h0000, run: 32'h00000000, crit: 2'h0, locked: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign locked_o = st_reg.locked;
endmodule

// ---- sfrl_regs.sv ----
/*
  Register bank: second synth FEC ratio, synth output enables, lock criterion select.
  Assumes a byte-wide configuration port (address, write/read strobe) on clk_i, and
  that the synthesis and DPLL datapaths consume the settings driven out here.
*/
`timescale 1ns/100ps
module sfrl_regs
  import sfrl_pkg::*;
#(
  parameter int WIN10_TICKS = SFRL_WIN10_MS * 1000,
  parameter int WIN1_TICKS = SFRL_WIN1_MS * 1000
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [6:0] cfg_addr_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  input wire logic [15:0] base_frequency_hz_i,
  input wire logic [15:0] base_multiplier_i,
  input wire logic [31:0] phase_err_ns_i,
  input wire logic synth0_clk_i,
  input wire logic synth1_clk_i,
  output logic [15:0] fec_ratio_numerator_o,
  output logic [15:0] fec_ratio_denominator_o,
  output logic [63:0] synth_freq_hz_o,
  output logic synth0_out_o,
  output logic synth1_out_o,
  output logic [1:0] lock_criterion_o,
  output logic dpll_lock_fail_o
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] ratio;
    logic [7:0] out_en;
    logic [7:0] lock_sel;
    logic [7:0] rdata;
    logic [63:0] freq;
  } sfrl_st_t;
  sfrl_st_t st_reg, st_next;
  logic locked;
  logic [47:0] freq_num;

  // byte lane of the ratio register: offset 0x5C is the most significant byte
  function automatic logic ratio_hit(input logic [6:0] a);
    ratio_hit = (a >= SFRL_RATIO_OFS) && (a <= SFRL_RATIO_OFS + 7'h03);
  endfunction

  // base times multiplier times sixteen; numerator multiply and denominator divide below
  assign freq_num = 48'(base_frequency_hz_i) * 48'(base_multiplier_i) * 48'(SFRL_FREQ_SCALE);

  // ----------------------------------------
  // register access
  // ----------------------------------------
  always_comb begin
    logic [1:0] lane;
    lane = 2'(SFRL_RATIO_OFS + 7'h03 - cfg_addr_i);
    st_next = st_reg;
    if (cfg_wr_i) begin
      if (ratio_hit(cfg_addr_i)) begin
        st_next.ratio[lane*8 +: 8] = cfg_wdata_i;
      end else if (cfg_addr_i == SFRL_OUT_EN_OFS) begin
        st_next.out_en = cfg_wdata_i; // reserved bits stored, never used
      end else if (cfg_addr_i == SFRL_LOCK_SEL_OFS) begin
        st_next.lock_sel = cfg_wdata_i;
      end
    end
    if (cfg_rd_i) begin
      if (ratio_hit(cfg_addr_i)) begin
        st_next.rdata = st_reg.ratio[lane*8 +: 8];
      end else if (cfg_addr_i == SFRL_OUT_EN_OFS) begin
        st_next.rdata = st_reg.out_en;
      end else if (cfg_addr_i == SFRL_LOCK_SEL_OFS) begin
        st_next.rdata = st_reg.lock_sel;
      end else begin
        st_next.rdata = 8'h00; // unmapped reads as zero
      end
    end
    // a zero denominator would be illegal; hold off to zero rather than divide by it
    if (st_reg.ratio[15:0] == 16'h0000) begin
      st_next.freq = 64'h0;
    end else begin
      st_next.freq = (64'(freq_num) * 64'(st_reg.ratio[31:SFRL_NUM_LSB])) / 64'(st_reg.ratio[15:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg <= '{ratio: SFRL_RATIO_RST, out_en: SFRL_OUT_EN_RST, lock_sel: SFRL_LOCK_SEL_RST,
                  rdata: 8'h00, freq: 64'h0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // lock qualification
  // ----------------------------------------
  sfrl_lock_qual #(
    .TICK_CYC(SFRL_TICK_CYC),
    .WIN10_TICKS(WIN10_TICKS),
    .WIN1_TICKS(WIN1_TICKS)
  ) u_lock (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .crit_i(st_reg.lock_sel[1:0]),
    .phase_err_ns_i(phase_err_ns_i),
    .locked_o(locked)
  );

  // outputs; synth gating is a plain AND since the synth clocks are only passed through
  assign cfg_rdata_o = st_reg.rdata;
  assign fec_ratio_numerator_o = st_reg.ratio[31:SFRL_NUM_LSB];
  assign fec_ratio_denominator_o = st_reg.ratio[15:0];
  assign synth_freq_hz_o = st_reg.freq;
  assign synth0_out_o = synth0_clk_i & st_reg.out_en[SFRL_SYNTH0_BIT];
  assign synth1_out_o = synth1_clk_i & st_reg.out_en[SFRL_SYNTH1_BIT];
  assign lock_criterion_o = st_reg.lock_sel[1:0];
  assign dpll_lock_fail_o = ~locked;
endmodule

// ---- sfrl_regs_chk.sv ----
/*
  Checker for the ratio, output enable and lock criterion register bank.
  Assumes it is bound onto sfrl_regs and sees only its ports.
*/
`timescale 1ns/100ps
module sfrl_regs_chk
  import sfrl_pkg::*;
#(
  parameter int WIN10_TICKS = SFRL_WIN10_MS * 1000,
  parameter int WIN1_TICKS = SFRL_WIN1_MS * 1000
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [6:0] cfg_addr_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic [15:0] base_frequency_hz_i,
  input wire logic [15:0] base_multiplier_i,
  input wire logic [31:0] phase_err_ns_i,
  input wire logic synth0_clk_i,
  input wire logic synth1_clk_i,
  input wire logic [15:0] fec_ratio_numerator_o,
  input wire logic [15:0] fec_ratio_denominator_o,
  input wire logic [63:0] synth_freq_hz_o,
  input wire logic synth0_out_o,
  input wire logic synth1_out_o,
  input wire logic [1:0] lock_criterion_o,
  input wire logic dpll_lock_fail_o
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic [1:0] en_reg;
  logic [1:0] crit_reg;
  logic ok;
  int unsigned good_reg;
  int unsigned thr;
  int unsigned win;
  logic [63:0] fexp;
  // division by zero only matters where the denominator is guarded below
  assign fexp = 64'(base_frequency_hz_i) * 64'(base_multiplier_i) * 64'(SFRL_FREQ_SCALE)
    * 64'(fec_ratio_numerator_o) / 64'(fec_ratio_denominator_o);
  assign thr = (lock_criterion_o == 2'h0) ? SFRL_THR36_NS : (lock_criterion_o == 2'h1) ? SFRL_THR1_NS : SFRL_THR10_NS;
  assign ok = phase_err_ns_i < thr;
  assign win = (^lock_criterion_o) ? WIN1_TICKS : WIN10_TICKS;
  // shadow enables and a run length of good cycles under one criterion
  always_ff @(posedge clk_i) begin
    en_reg <= reset_i ? 2'h3 : (cfg_wr_i && cfg_addr_i == 7'h71) ? cfg_wdata_i[1:0] : en_reg;
    crit_reg <= lock_criterion_o;
    good_reg <= (reset_i || !ok || crit_reg != lock_criterion_o) ? 0 : good_reg + 1;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  AST_SYN0_GATE:
    assert property (synth0_out_o == (synth0_clk_i & en_reg[0])) else $error("synth0 gating wrong");
  AST_SYN1_GATE:
    assert property (synth1_out_o == (synth1_clk_i & en_reg[1])) else $error("synth1 gating wrong");
  AST_CRIT_WRITE:
    assert property (cfg_wr_i && cfg_addr_i == 7'h72 |=> lock_criterion_o == $past(cfg_wdata_i[1:0]))
    else $error("criterion not taken");
  AST_NUM_WRITE:
    assert property (cfg_wr_i && cfg_addr_i == 7'h5C |=> fec_ratio_numerator_o[15:8] == $past(cfg_wdata_i))
    else $error("numerator byte not taken");
  AST_FREQ_CALC:
    assert property (fec_ratio_denominator_o != 16'h0 |=> synth_freq_hz_o == $past(fexp))
    else $error("frequency wrong");
  AST_LOCK_CLEAR:
    assert property (!ok |=> dpll_lock_fail_o) else $error("lock kept with large error");
  AST_LOCK_EARLY:
    assert property ($fell(dpll_lock_fail_o) |-> good_reg >= (win - 1) * SFRL_TICK_CYC) else $error("lock too early");
  AST_LOCK_LATE:
    assert property (good_reg > (win + 1) * SFRL_TICK_CYC |-> !dpll_lock_fail_o) else $error("lock too late");
endmodule

// ---- test_sfrl_regs.sv ----
/*
  Testbench for sfrl_regs: register table, reset values, the four lock criteria.
  Assumes short lock windows of 4 and 8 ticks.
*/
`timescale 1ns/100ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin bad_count++; $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module test_sfrl_regs;
  import sfrl_pkg::*;
  logic clk_i = 0, reset_i = 1, cfg_wr_i = 0, cfg_rd_i = 0, synth0_clk_i = 0, synth1_clk_i = 0;
  logic [6:0] cfg_addr_i = 0;
  logic [7:0] cfg_wdata_i = 0, cfg_rdata_o;
  logic [15:0] base_frequency_hz_i = 16'h9C40, base_multiplier_i = 16'h0798;
  logic [15:0] fec_ratio_numerator_o, fec_ratio_denominator_o;
  logic [31:0] phase_err_ns_i = 0;
  logic [63:0] synth_freq_hz_o;
  logic synth0_out_o, synth1_out_o, dpll_lock_fail_o;
  logic [1:0] lock_criterion_o;
  int bad_count = 0, compares = 0, cyc = 0;
  int thr [4] = '{SFRL_THR36_NS, SFRL_THR1_NS, SFRL_THR10_NS, SFRL_THR10_NS};
  // address, write data, expected read back
  logic [7:0] rows [7][3] = '{'{8'h5C, 8'h00, 8'h00}, '{8'h5D, 8'hFF, 8'hFF}, '{8'h5E, 8'h00, 8'h00},
    '{8'h5F, 8'hED, 8'hED}, '{8'h71, 8'hFE, 8'hFE}, '{8'h72, 8'hAB, 8'hAB}, '{8'h60, 8'h5A, 8'h00}};
  sfrl_regs #(.WIN10_TICKS(8), .WIN1_TICKS(4)) dut_u (.*);
  always #4 clk_i = ~clk_i;
  // cycle count, timeout, and slow toggles standing in for synth clocks
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 10000) begin
      bad_count++;
      print_verdict();
    end
    #1 synth0_clk_i = cyc[1];
    synth1_clk_i = cyc[2];
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1 cfg_addr_i = a;
    cfg_wdata_i = d;
    cfg_wr_i = 1;
    @(posedge clk_i);
    #1 cfg_wr_i = 0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e, input string n);
    @(posedge clk_i);
    #1 cfg_addr_i = a;
    cfg_rd_i = 1;
    @(posedge clk_i);
    #1 cfg_rd_i = 0;
    `CHK(n, e, cfg_rdata_o)
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // table first, then reset values and lock qualification by hand
  initial begin
    repeat (16) @(posedge clk_i);
    #1 reset_i = 0;
    foreach (rows[i]) begin
      wr(rows[i][0][6:0], rows[i][1]);
      rd(rows[i][0][6:0], rows[i][2], "table read");
    end
    `CHK("numerator", 16'h00FF, fec_ratio_numerator_o)
    `CHK("frequency", 64'd40000 * 64'd1944 * 64'd16 * 64'd255 / 64'd237, synth_freq_hz_o)
    `CHK("synth0 off", 1'b0, synth0_out_o)
    `CHK("synth1 on", synth1_clk_i, synth1_out_o)
    `CHK("denominator", 16'h00ED, fec_ratio_denominator_o)
    `CHK("criterion", 2'b11, lock_criterion_o)
    @(posedge clk_i);
    #1 reset_i = 1;
    @(posedge clk_i);
    #1 reset_i = 0;
    `CHK("lock fail rst", 1'b1, dpll_lock_fail_o)
    rd(7'h5D, 8'h01, "ratio rst");
    rd(7'h5F, 8'h01, "ratio rst");
    rd(7'h71, 8'h03, "enable rst");
    rd(7'h72, 8'hAA, "crit rst");
    `CHK("freq rst", 64'd40000 * 64'd1944 * 64'd16, synth_freq_hz_o)
    // threshold itself must fail, one below must lock within one tick past the window
    for (int c = 0; c < 4; c++) begin
      wr(7'h72, {6'b101010, 2'(c)});
      phase_err_ns_i = thr[c];
      repeat (2) @(posedge clk_i);
      #1 `CHK("lock lost", 1'b1, dpll_lock_fail_o)
      phase_err_ns_i = thr[c] - 1;
      repeat ((c == 1 || c == 2 ? 5 : 9) * 125 + 5) @(posedge clk_i);
      #1 `CHK("locked", 1'b0, dpll_lock_fail_o)
    end
    print_verdict();
  end
endmodule
bind sfrl_regs sfrl_regs_chk #(.WIN10_TICKS(WIN10_TICKS), .WIN1_TICKS(WIN1_TICKS)) chk_u (.*);
